// ==== rtl/sar_adc_pkg.sv ====
// shared constants and types for the successive-approximation converter sequencer
// assumes a single bus clock; the converter clock is a divided tick of it
package sar_adc_pkg;
    localparam logic [15:0] SC_OFFSET = 16'h0038;
    localparam logic [15:0] DATA_OFFSET = 16'h0039;
    localparam int DONE_BIT = 7;
    localparam int IRQEN_BIT = 6;
    localparam int REPEAT_BIT = 5;
    localparam logic [7:0] SC_RESET = 8'h1F;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [4:0] SEL_LAST_PIN = 5'h0E;
    localparam logic [4:0] SEL_HIGH_REF = 5'h1D;
    localparam logic [4:0] SEL_LOW_REF = 5'h1E;
    localparam logic [4:0] SEL_POWER_OFF = 5'h1F;
    localparam logic [7:0] TRIAL_START = 8'h80;
    localparam logic [3:0] CONV_LAST_STEP = 4'hF;
    localparam int CONV_CLOCKS = 16;
    localparam int RESULT_BITS = 8;
    localparam int NUM_CHANNELS = 15;
    localparam int ADC_DIV_DEFAULT = 40;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT
    } conv_state_t;
endpackage : sar_adc_pkg

// ==== rtl/sar_adc_sequencer.sv ====
// converter control: register port, sequencing, pin override, result and done/irq
// assumes an external comparator answering comparator_i for trial_code_o each cycle
//
// Notes on behaviour
// - a conversion lasts sixteen converter clock periods.
// - a control write starts conversion at the next converter clock edge.
// - write-to-result latency is at most seventeen converter periods.
// - at the end the result is stored and flag or interrupt is raised on the same edge.
// - the selected pin is forced to analog input; port writes cannot drive it.
// - unselected shared pins stay under ordinary port control.
// - reading a converter pin returns 0 if direction 0, else the latch.
// - code saturates at full scale above high, zero below low reference.
// - binary search gives a monotonic 8-bit code without missing codes.
// - continuous mode reconverts until cleared, overwriting unread results.
// - done flag sets each conversion without interrupt enable; control write or data read clears it.
// - with interrupt enable, each conversion raises an interrupt; flag stays 0.
// - the converter keeps running in wait mode and its interrupt wakes.
// - stop mode aborts any conversion; afterwards the sequencer stays idle until a control write.
// - at most one of fifteen pin channels feeds the converter; none for codes above 0E.
// - select codes 0-14 pins, 1D high ref, 1E low ref, 1F power off.
// - the pending interrupt drops on data read or control write.
`timescale 1ns/1ps
module sar_adc_sequencer #(
    parameter int ADC_DIV = sar_adc_pkg::ADC_DIV_DEFAULT
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire sar_adc_pkg::reg_req_t reg_req_i,
    output logic [7:0] rd_data_o,
    input wire logic stop_mode_i,
    input wire logic wait_mode_i,
    input wire logic comparator_i,
    output logic [7:0] trial_code_o,
    output logic sample_o,
    output logic [4:0] input_select_o,
    output logic converter_power_o,
    output logic [14:0] analog_select_o,
    input wire logic [14:0] port_latch_i,
    input wire logic [14:0] port_dir_i,
    input wire logic [14:0] port_pin_i,
    output logic [14:0] port_read_o,
    output logic [14:0] port_drive_o,
    output logic [14:0] port_oe_o,
    output logic irq_o,
    output logic wake_o
);
    localparam int DIV_W = $clog2(ADC_DIV);

    // the divider needs at least two states to make a tick
    if (ADC_DIV < 2) begin : g_div_check
        $error("ADC_DIV must be at least 2");
    end

    logic [4:0] select_reg;
    logic irq_enable_reg;
    logic repeat_reg;
    logic done_flag_reg;
    logic irq_pending_reg;
    logic [7:0] data_reg;
    logic [7:0] trial_reg;
    logic [7:0] trial_next;
    logic [7:0] rd_data_reg;
    logic [3:0] step_reg;
    logic [DIV_W-1:0] div_reg;
    logic sample_reg;
    sar_adc_pkg::conv_state_t state_reg;

    logic sc_write;
    logic data_read;
    logic tick;
    logic powered;
    logic done_pulse;
    logic [2:0] bit_pos;

    assign sc_write = reg_req_i.wr && (reg_req_i.addr == sar_adc_pkg::SC_OFFSET);
    assign data_read = reg_req_i.rd && (reg_req_i.addr == sar_adc_pkg::DATA_OFFSET);
    assign powered = (select_reg != sar_adc_pkg::SEL_POWER_OFF);
    assign tick = (div_reg == DIV_W'(ADC_DIV - 1));
    assign done_pulse = (state_reg == sar_adc_pkg::ST_CONVERT) && tick && !stop_mode_i
        && (step_reg == sar_adc_pkg::CONV_LAST_STEP);

    // converter clock as a divided tick; held still in stop mode
    always_ff @(posedge clk_i) begin
        if (reset_i || stop_mode_i) begin
            div_reg <= '0;
        end else if (tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // control fields
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            select_reg <= sar_adc_pkg::SC_RESET[4:0];
            irq_enable_reg <= sar_adc_pkg::SC_RESET[sar_adc_pkg::IRQEN_BIT];
            repeat_reg <= sar_adc_pkg::SC_RESET[sar_adc_pkg::REPEAT_BIT];
        end else if (sc_write) begin
            select_reg <= reg_req_i.wdata[4:0];
            irq_enable_reg <= reg_req_i.wdata[sar_adc_pkg::IRQEN_BIT];
            repeat_reg <= reg_req_i.wdata[sar_adc_pkg::REPEAT_BIT];
        end
    end

    // one binary-search step per tick over the first eight steps
    always_comb begin
        bit_pos = 3'(7 - int'(step_reg[2:0]));
        trial_next = trial_reg;
        if (!step_reg[3]) begin
            trial_next[bit_pos] = comparator_i;
            if (bit_pos != 3'h0) begin
                trial_next[bit_pos - 3'h1] = 1'b1;
            end
        end
    end

    // sequencer; a newer write restarts, stop or power-off aborts
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= sar_adc_pkg::ST_IDLE;
            step_reg <= '0;
            trial_reg <= sar_adc_pkg::TRIAL_START;
            sample_reg <= 1'b0;
        end else if (stop_mode_i) begin
            state_reg <= sar_adc_pkg::ST_IDLE;
            step_reg <= '0;
            sample_reg <= 1'b0;
        end else if (!sc_write && !powered) begin
            state_reg <= sar_adc_pkg::ST_IDLE;
            step_reg <= '0;
            sample_reg <= 1'b0;
        end else if (sc_write) begin
            // the new select decides, so a write that powers up also starts
            if (reg_req_i.wdata[4:0] == sar_adc_pkg::SEL_POWER_OFF) begin
                state_reg <= sar_adc_pkg::ST_IDLE;
            end else begin
                state_reg <= sar_adc_pkg::ST_ARMED;
            end
            step_reg <= '0;
            sample_reg <= 1'b0;
        end else begin
            case (state_reg)
                sar_adc_pkg::ST_IDLE: begin
                    sample_reg <= 1'b0;
                end
                sar_adc_pkg::ST_ARMED: begin
                    // at most one tick period of wait before sampling
                    if (tick) begin
                        state_reg <= sar_adc_pkg::ST_CONVERT;
                        step_reg <= '0;
                        trial_reg <= sar_adc_pkg::TRIAL_START;
                        sample_reg <= 1'b1;
                    end
                end
                sar_adc_pkg::ST_CONVERT: begin
                    if (tick) begin
                        sample_reg <= 1'b0;
                        if (done_pulse) begin
                            step_reg <= '0;
                            trial_reg <= sar_adc_pkg::TRIAL_START;
                            if (repeat_reg) begin
                                sample_reg <= 1'b1;
                            end else begin
                                state_reg <= sar_adc_pkg::ST_IDLE;
                            end
                        end else begin
                            step_reg <= step_reg + 4'h1;
                            trial_reg <= trial_next;
                        end
                    end
                end
                default: begin
                    state_reg <= sar_adc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // result and notification on one edge, so software sees them together
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_reg <= sar_adc_pkg::DATA_RESET;
        end else if (done_pulse) begin
            data_reg <= trial_next;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_flag_reg <= 1'b0;
        end else if (done_pulse && !irq_enable_reg) begin
            done_flag_reg <= 1'b1;
        end else if (sc_write || data_read) begin
            done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_pending_reg <= 1'b0;
        end else if (done_pulse && irq_enable_reg) begin
            irq_pending_reg <= 1'b1;
        end else if (sc_write || data_read) begin
            irq_pending_reg <= 1'b0;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i || !reg_req_i.rd) begin
            rd_data_reg <= '0;
        end else if (reg_req_i.addr == sar_adc_pkg::SC_OFFSET) begin
            rd_data_reg <= {done_flag_reg, irq_enable_reg, repeat_reg, select_reg};
        end else if (data_read) begin
            rd_data_reg <= data_reg;
        end else begin
            rd_data_reg <= '0;
        end
    end

    // pin sharing; code above the last pin selects no pin at all
    always_comb begin
        analog_select_o = '0;
        if (powered && select_reg <= sar_adc_pkg::SEL_LAST_PIN) begin
            analog_select_o[select_reg[3:0]] = 1'b1;
        end
    end

    assign port_oe_o = port_dir_i & ~analog_select_o;
    assign port_drive_o = port_latch_i;
    // analog pin reads latch or 0, never the pin level
    assign port_read_o = (port_dir_i & port_latch_i)
        | (~port_dir_i & ~analog_select_o & port_pin_i);

    assign rd_data_o = rd_data_reg;
    assign trial_code_o = trial_reg;
    assign sample_o = sample_reg;
    assign input_select_o = select_reg;
    assign converter_power_o = powered && !stop_mode_i;
    assign irq_o = irq_pending_reg;
    // wait mode leaves the sequencer running; the interrupt is the wake source
    assign wake_o = irq_pending_reg && wait_mode_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_start_write;
        sc_write && reg_req_i.wdata[4:0] != sar_adc_pkg::SEL_POWER_OFF && !stop_mode_i;
    endsequence

    sequence s_armed_tick;
        state_reg == sar_adc_pkg::ST_ARMED && tick && !sc_write && !stop_mode_i && powered;
    endsequence

    a_start_arms: assert property (s_start_write |=> state_reg == sar_adc_pkg::ST_ARMED)
        else $error("write did not arm a conversion");

    a_start_sample: assert property (s_armed_tick
        |=> state_reg == sar_adc_pkg::ST_CONVERT && step_reg == 4'h0 && sample_o)
        else $error("conversion did not begin on the converter tick");

    a_conv_length: assert property (done_pulse
        |-> $past(state_reg, ADC_DIV) == sar_adc_pkg::ST_CONVERT && $past(step_reg, ADC_DIV) == 4'hE)
        else $error("conversion ended at the wrong step");

    a_done_flag: assert property (done_pulse && !irq_enable_reg
        |=> done_flag_reg && !irq_o && data_reg == $past(trial_next))
        else $error("result or done flag missing after conversion");

    a_irq_raise: assert property (done_pulse && irq_enable_reg |=> irq_o && !done_flag_reg)
        else $error("interrupt not raised or flag wrongly set");

    a_flag_clear: assert property ((sc_write || data_read) && !done_pulse |=> !done_flag_reg)
        else $error("done flag not cleared by access");

    a_irq_withdraw: assert property (data_read && !done_pulse |=> !irq_o)
        else $error("interrupt not withdrawn by data read");

    a_repeat_run: assert property (done_pulse && repeat_reg && !sc_write && !stop_mode_i && powered
        |=> state_reg == sar_adc_pkg::ST_CONVERT ##1 step_reg == 4'h0)
        else $error("continuous mode did not restart");

    a_stop_abort: assert property (stop_mode_i
        |=> state_reg == sar_adc_pkg::ST_IDLE && !converter_power_o == stop_mode_i)
        else $error("stop mode did not abort conversion");

    a_pin_override: assert property ((analog_select_o & port_oe_o) == 15'h0000
        && (analog_select_o & ~port_dir_i & port_read_o) == 15'h0000)
        else $error("selected pin still under port control");

    a_power_idle: assert property (!powered && !sc_write |=> state_reg == sar_adc_pkg::ST_IDLE)
        else $error("converter left idle while powered off");

    a_read_result: assert property (data_read |=> rd_data_o == $past(data_reg))
        else $error("result read returned the wrong value");

    a_read_control: assert property (reg_req_i.rd && reg_req_i.addr == sar_adc_pkg::SC_OFFSET
        |=> rd_data_o[sar_adc_pkg::DONE_BIT] == $past(done_flag_reg) && rd_data_o[4:0] == $past(select_reg))
        else $error("control read returned the wrong value");

    a_mux_one_hot: assert property ($onehot0(analog_select_o)
        && ((analog_select_o != 15'h0000) == (powered && select_reg <= sar_adc_pkg::SEL_LAST_PIN)))
        else $error("input multiplexer not one-hot");

    a_free_pins: assert property ((~analog_select_o & port_oe_o) == (~analog_select_o & port_dir_i)
        && port_drive_o == port_latch_i)
        else $error("unselected pin not under port control");

    a_read_latch: assert property ((port_dir_i & port_read_o) == (port_dir_i & port_latch_i))
        else $error("output pin read does not show the latch");

    a_trial_steady: assert property (state_reg == sar_adc_pkg::ST_CONVERT && !tick && !sc_write
        && !stop_mode_i |=> $stable(trial_code_o))
        else $error("trial code moved between converter ticks");

    a_first_trial: assert property (s_armed_tick |=> trial_code_o == sar_adc_pkg::TRIAL_START)
        else $error("search did not start from mid scale");

    sequence s_first_step;
        state_reg == sar_adc_pkg::ST_CONVERT && tick && step_reg == 4'h0 && !sc_write && !stop_mode_i && powered;
    endsequence

    a_msb_decide: assert property (s_first_step
        |=> trial_code_o[7] == $past(comparator_i) && trial_code_o[6])
        else $error("top bit not decided by the comparator");

    a_result_hold: assert property (!done_pulse |=> $stable(data_reg))
        else $error("result changed without a conversion");

    a_wake_source: assert property (wake_o == (irq_o && wait_mode_i))
        else $error("wake request does not follow the interrupt");

    a_stop_frozen: assert property (stop_mode_i && !sc_write && !data_read
        |=> $stable(data_reg) && $stable(done_flag_reg) && $stable(irq_pending_reg))
        else $error("conversion result delivered during stop");

    a_single_stop: assert property (done_pulse && !repeat_reg && !sc_write
        |=> state_reg == sar_adc_pkg::ST_IDLE)
        else $error("single conversion did not stop");
endmodule : sar_adc_sequencer

// ==== verification/sar_adc_sequencer_tb.sv ====
// self-checking bench for the converter sequencer with a comparator model
// assumes a 40 MHz clock and a shortened converter clock divider
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
    localparam int DIV = 4;
    localparam int FAST = 14 * DIV;
    // worst case start skew plus result and flag stages
    localparam int SLOW = 17 * DIV + 2;
    localparam logic [15:0] SC = sar_adc_pkg::SC_OFFSET;
    localparam logic [15:0] DAT = sar_adc_pkg::DATA_OFFSET;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    sar_adc_pkg::reg_req_t req = '0;
    logic stop_i = 1'b0, wait_i = 1'b0, cmp, pwr, irq, wake, smp, smp_d = 1'b0;
    logic [7:0] rdata, trial, rv, level = 8'h00;
    logic [4:0] sel;
    logic [14:0] latch = 15'h0000, dir = 15'h0000, pin = 15'h0000, asel, pread, pdrive, poe;
    int n_errors = 0, n_compared = 0, cycles = 0, n_samples = 0;

    sar_adc_sequencer #(.ADC_DIV(DIV)) uut (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(req),
        .rd_data_o(rdata), .stop_mode_i(stop_i), .wait_mode_i(wait_i), .comparator_i(cmp),
        .trial_code_o(trial), .sample_o(smp), .input_select_o(sel), .converter_power_o(pwr),
        .analog_select_o(asel), .port_latch_i(latch), .port_dir_i(dir), .port_pin_i(pin),
        .port_read_o(pread), .port_drive_o(pdrive), .port_oe_o(poe), .irq_o(irq), .wake_o(wake));
    sar_comparator_model comp (.clk_i(clk_i), .power_i(pwr), .select_i(sel), .trial_i(trial),
        .level_i(level), .cmp_o(cmp));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task results();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    always @(posedge clk_i) begin
        cycles++;
        // each conversion opens with exactly one sample phase
        smp_d <= smp;
        if (smp && !smp_d) n_samples++;
        if (cycles == 8000) begin
            n_errors++;
            results();
        end
    end

    task chk(input string what, input logic [14:0] got, input logic [14:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [15:0] a);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd

    task run(input logic [7:0] c, input logic [7:0] lv, input logic [7:0] exp);
        int base;
        base = n_samples;
        @(posedge clk_i);
        level <= lv;
        wr(SC, c);
        repeat (FAST) @(posedge clk_i);
        rd(SC);
        chk("early_flag", 15'(rv[7]), 15'h0000);
        chk("early_irq", 15'(irq), 15'h0000);
        repeat (SLOW - FAST) @(posedge clk_i);
        rd(SC);
        chk("flag", 15'(rv[7]), 15'(!c[6]));
        chk("irq", 15'(irq), 15'(c[6]));
        if (c[6]) chk("wake", 15'(wake), 15'(wait_i));
        rd(DAT);
        chk("data", 15'(rv), 15'(exp));
        chk("irq_drop", 15'(irq), 15'h0000);
        rd(SC);
        chk("flag_drop", 15'(rv[7]), 15'h0000);
        chk("samples", 15'(n_samples - base), c[5] ? 15'h0002 : 15'h0001);
    endtask : run

    task t_reset();
        rd(SC);
        chk("sc_reset", 15'(rv), 15'(sar_adc_pkg::SC_RESET));
        chk("power_reset", 15'(pwr), 15'h0000);
        wr(DAT, 8'hAA);
        wr(SC, 8'h9F);
        rd(SC);
        chk("flag_ro", 15'(rv), 15'h001F);
        rd(DAT);
        chk("data_ro", 15'(rv), 15'h0000);
        rd(16'h0040);
        chk("unmapped", 15'(rv), 15'h0000);
    endtask : t_reset

    task t_ports();
        wr(SC, 8'h03);
        latch <= 15'h5555;
        dir <= 15'h7FFF;
        @(posedge clk_i);
        #1 chk("oe", poe, 15'h7FF7);
        chk("drive", pdrive, 15'h5555);
        chk("read_dir1", pread, 15'h5555);
        @(posedge clk_i);
        dir <= 15'h0000;
        pin <= 15'h7FFF;
        @(posedge clk_i);
        #1 chk("read_dir0", pread, 15'h7FF7);
        chk("oe_off", poe, 15'h0000);
    endtask : t_ports

    task t_cont();
        run(8'h20, 8'h11, 8'h11);
        @(posedge clk_i);
        level <= 8'h22;
        repeat (2 * SLOW) @(posedge clk_i);
        rd(SC);
        chk("cont_flag", 15'(rv[7]), 15'h0001);
        rd(DAT);
        chk("cont_data", 15'(rv), 15'h0022);
    endtask : t_cont

    task t_stop();
        @(posedge clk_i);
        level <= 8'h3C;
        wr(SC, 8'h07);
        repeat (20) @(posedge clk_i);
        stop_i <= 1'b1;
        @(posedge clk_i);
        #1 chk("stop_power", 15'(pwr), 15'h0000);
        repeat (SLOW) @(posedge clk_i);
        rd(SC);
        chk("stop_abort", 15'(rv[7]), 15'h0000);
        @(posedge clk_i);
        stop_i <= 1'b0;
        repeat (SLOW) @(posedge clk_i);
        run(8'h07, 8'h3C, 8'h3C);
    endtask : t_stop

    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_ports();
        // every pin code; no timer clock here, so channel fourteen is free
        for (int ch = 0; ch < 15; ch++) begin
            run(8'(ch), 8'(ch * 17), 8'(ch * 17));
            chk("mux", asel, 15'h0001 << ch);
        end
        run({3'b000, sar_adc_pkg::SEL_HIGH_REF}, 8'h00, 8'hFF);
        run({3'b000, sar_adc_pkg::SEL_LOW_REF}, 8'hFF, 8'h00);
        @(posedge clk_i);
        wait_i <= 1'b1;
        run(8'h45, 8'hC3, 8'hC3);
        t_cont();
        t_stop();
        wr(SC, 8'h1F);
        #1 chk("off_power", 15'(pwr), 15'h0000);
        chk("off_mux", asel, 15'h0000);
        results();
    end
endmodule : sar_adc_sequencer_tb

// ==== verification/sar_comparator_model.sv ====
// comparator model: selected input level against the sequencer's trial code
// assumes select, power and trial come straight from the sequencer outputs
`timescale 1ns/1ps
module sar_comparator_model (
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic [4:0] select_i,
    input wire logic [7:0] trial_i,
    input wire logic [7:0] level_i,
    output logic cmp_o
);
    logic [8:0] vin;
    logic junk_reg = 1'b0;
    // unpowered comparator gives nothing usable, so it wanders
    always_ff @(posedge clk_i) begin
        junk_reg <= ~junk_reg;
    end
    always_comb begin
        vin = {1'b0, level_i};
        if (select_i == sar_adc_pkg::SEL_HIGH_REF) vin = 9'h1FF;
        if (select_i == sar_adc_pkg::SEL_LOW_REF) vin = 9'h000;
    end
    assign cmp_o = power_i ? ({1'b0, trial_i} <= vin) : junk_reg;
endmodule : sar_comparator_model
